// ==== core/acs_params.svh ====
// offsets, field positions and timing counts of the conversion sequencer
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// register byte offsets
`define ACS_OFF_CTRL 8'h00
`define ACS_OFF_RES_HI 8'h04
`define ACS_OFF_RES_LO 8'h08
`define ACS_OFF_IRQ_ST 8'h0c
`define ACS_OFF_IRQ_MASK 8'h10
`define ACS_OFF_INFO 8'h14

// converter_control_zero fields
`define ACS_CTRL_ON 0
`define ACS_CTRL_GO 1
`define ACS_CTRL_CKS_LO 2
`define ACS_CTRL_CKS_HI 4
`define ACS_CTRL_JUST 7
`define ACS_CKS_RC 3'h7

// interrupt status and mask fields
`define ACS_IRQ_DONE 0
`define ACS_IRQ_ABORT 1
`define ACS_IRQ_TRIG 2
`define ACS_IRQ_W 3

// info register fields
`define ACS_INFO_BUSY 0
`define ACS_INFO_SUSP 1
`define ACS_INFO_AEN 2
`define ACS_INFO_ST_LO 4

// timing
`define ACS_CLK_NS 8
`define ACS_INSTR_NS 32
`define ACS_INSTR_CYC ((`ACS_INSTR_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`define ACS_RC_TAD_NS 1600
`define ACS_RC_TAD_CYC (`ACS_RC_TAD_NS / `ACS_CLK_NS)
`define ACS_RES_BITS 10

`endif

// ==== core/acs_pkg.sv ====
// types shared by the conversion sequencer
package acs_pkg;

    typedef enum logic [1:0] {
        acs_st_idle = 2'b00,
        acs_st_wait = 2'b01,
        acs_st_acq = 2'b10,
        acs_st_conv = 2'b11
    } acs_state_t;

endpackage

// ==== core/acs_clkdiv.sv ====
// conversion clock and instruction cycle enable generator
`include "acs_params.svh"

module acs_clkdiv #(
    parameter int INSTR_CYC = 4,
    parameter int RC_CYC = 200
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // selection
    input wire logic [2:0] i_cks,
    // enables
    output logic o_tad,
    output logic o_instr
);
    logic [6:0] sys_q;
    logic [15:0] rc_q;
    logic [7:0] ins_q;
    logic [6:0] sys_mask;
    logic sys_tick;
    logic rc_tick;

    // the rc divider runs free so it stands in for an oscillator independent of the core
    assign sys_mask = 7'h7f >> (3'd6 - i_cks);
    assign sys_tick = ((sys_q & sys_mask) == sys_mask);
    assign rc_tick = (rc_q == 16'(RC_CYC - 1));

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_q <= 7'h00;
            rc_q <= 16'h0000;
            ins_q <= 8'h00;
        end else begin
            sys_q <= sys_q + 7'h01;
            rc_q <= rc_tick ? 16'h0000 : rc_q + 16'h0001;
            ins_q <= (ins_q == 8'(INSTR_CYC - 1)) ? 8'h00 : ins_q + 8'h01;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_tad <= 1'b0;
            o_instr <= 1'b0;
        end else begin
            o_tad <= (i_cks == `ACS_CKS_RC) ? rc_tick : sys_tick;
            o_instr <= (ins_q == 8'(INSTR_CYC - 1));
        end
    end

endmodule

// ==== core/acs_sar.sv ====
// successive approximation register with abort fill
module acs_sar #(
    parameter int BITS = 10
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // control
    input wire logic i_start,
    input wire logic i_step,
    input wire logic i_cmp,
    // results
    output logic [BITS-1:0] o_trial,
    output logic [BITS-1:0] o_partial,
    output logic o_last
);
    logic [BITS-1:0] ptr_q;
    logic [BITS:0] above;
    logic [BITS-1:0] unres;
    logic last_val;

    assign above = {ptr_q, 1'b0};
    assign unres = ptr_q | (ptr_q - BITS'(1));
    // with no bit resolved yet the fill value is zero
    assign last_val = |({1'b0, o_trial} & above);
    assign o_last = ptr_q[0];

    genvar gi;
    generate
        for (gi = 0; gi < BITS; gi++) begin : g_fill
            assign o_partial[gi] = unres[gi] ? last_val : o_trial[gi]; // R6
        end
    endgenerate

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ptr_q <= '0;
            o_trial <= '0;
        end else if (i_start) begin
            ptr_q <= {1'b1, {(BITS-1){1'b0}}};
            o_trial <= {1'b1, {(BITS-1){1'b0}}};
        end else if (i_step && ptr_q != '0) begin
            o_trial <= (i_cmp ? o_trial : (o_trial & ~ptr_q)) | (ptr_q >> 1);
            ptr_q <= ptr_q >> 1;
        end
    end

endmodule

// ==== core/acs_top.sv ====
// conversion sequencer with ahb-lite registers
// Overview of operation
// (R1) converter is powered only while converter_on is one
// (R2) writing go as one while converter is on starts a conversion
// (R3) software should set go in a separate write from converter_on
// (R4) completion clears go, sets done flag, loads both result bytes
// (R5) software clearing go mid-conversion stops it and loads the partial value
// (R6) unresolved bits of an aborted result copy the last resolved bit
// (R7) reset returns registers to reset values, powers off, drops conversion
// (R8) conversion survives sleep only with the dedicated rc clock selected
// (R9) rc clock start waits one extra instruction cycle after go
// (R10) completion in sleep with done interrupt enabled wakes the core
// (R11) completion in sleep with interrupt disabled powers off, converter_on stays
// (R12) sleep with non-rc clock aborts and powers off, converter_on stays
// (R13) compare unit four trigger sets go and clears timer one
// (R14) software must meet timing itself when trigger-started
// (R15) result_high_byte is eight bits, read-write, not reset
// (R16) left-justified high byte holds result bits nine to two
// (R17) left-justified low byte holds bits one and zero at seven and six
// (R18) go reads one while a conversion is in progress
`include "acs_params.svh"

module acs_top
    import acs_pkg::*;
#(
    parameter int RC_TAD_CYC = `ACS_RC_TAD_CYC,
    parameter int INSTR_CYC = `ACS_INSTR_CYC
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [7:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // analog front end
    input wire logic i_cmp,
    output logic o_analog_en,
    output logic o_sample,
    output logic [`ACS_RES_BITS-1:0] o_dac_code,
    // core and peripherals
    input wire logic i_sleep,
    input wire logic i_trig_special,
    output logic o_timer_one_clear,
    output logic o_wake,
    output logic o_irq
);
    localparam int RB = `ACS_RES_BITS;

    // bus state
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic addr_ok;
    logic wr_ctrl;
    logic wr_st;
    // control register
    logic on_q;
    logic go_q;
    logic [2:0] cks_q;
    logic just_q;
    logic rc_sel;
    // results and interrupts
    logic [7:0] res_hi_q;
    logic [7:0] res_lo_q;
    logic [`ACS_IRQ_W-1:0] st_q;
    logic [`ACS_IRQ_W-1:0] mask_q;
    logic [`ACS_IRQ_W-1:0] ev;
    // sequencer
    acs_state_t state_q;
    logic suspend_q;
    logic tad;
    logic instr;
    logic sar_start;
    logic sar_step;
    logic sar_last;
    logic [RB-1:0] sar_trial;
    logic [RB-1:0] sar_partial;
    logic busy;
    logic sw_go_set;
    logic sw_go_clr;
    logic conv_done;
    logic sleep_abort;
    logic off_abort;
    logic any_abort;
    logic load_full;
    logic load_part;
    logic [RB-1:0] load_val;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------ bus slave
    assign addr_ok = i_hsel && i_htrans[1] && i_hready;
    assign o_hreadyout = !rd_pend_q;
    assign o_hresp = 1'b0;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            rd_pend_q <= 1'b0;
            if (i_hready) begin
                wr_pend_q <= addr_ok && i_hwrite;
                rd_pend_q <= addr_ok && !i_hwrite;
                if (addr_ok) begin
                    addr_q <= i_haddr;
                end
            end
        end
    end

    // reads take one wait state so a write just before is always visible
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (addr_q)
            `ACS_OFF_CTRL: begin
                rd_mux[`ACS_CTRL_ON] = on_q;
                rd_mux[`ACS_CTRL_GO] = go_q; // R18
                rd_mux[`ACS_CTRL_CKS_HI:`ACS_CTRL_CKS_LO] = cks_q;
                rd_mux[`ACS_CTRL_JUST] = just_q;
            end
            `ACS_OFF_RES_HI: rd_mux[7:0] = res_hi_q;
            `ACS_OFF_RES_LO: rd_mux[7:0] = res_lo_q;
            `ACS_OFF_IRQ_ST: rd_mux[`ACS_IRQ_W-1:0] = st_q;
            `ACS_OFF_IRQ_MASK: rd_mux[`ACS_IRQ_W-1:0] = mask_q;
            `ACS_OFF_INFO: begin
                rd_mux[`ACS_INFO_BUSY] = busy;
                rd_mux[`ACS_INFO_SUSP] = suspend_q;
                rd_mux[`ACS_INFO_AEN] = o_analog_en;
                rd_mux[`ACS_INFO_ST_LO+1:`ACS_INFO_ST_LO] = state_q;
            end
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_hrdata <= 32'h0000_0000;
        end else if (rd_pend_q) begin
            o_hrdata <= rd_mux;
        end
    end

    assign wr_ctrl = wr_pend_q && (addr_q == `ACS_OFF_CTRL);
    assign wr_st = wr_pend_q && (addr_q == `ACS_OFF_IRQ_ST);

    // ------------------------------------------------------------ control register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            on_q <= 1'b0; // R7
            cks_q <= 3'h0;
            just_q <= 1'b0;
        end else if (wr_ctrl) begin
            on_q <= i_hwdata[`ACS_CTRL_ON];
            cks_q <= i_hwdata[`ACS_CTRL_CKS_HI:`ACS_CTRL_CKS_LO];
            just_q <= i_hwdata[`ACS_CTRL_JUST];
        end
    end

    assign rc_sel = (cks_q == `ACS_CKS_RC);
    // go counts only if the converter was already on before this write
    assign sw_go_set = wr_ctrl && i_hwdata[`ACS_CTRL_GO] && on_q; // R2 R3
    assign sw_go_clr = wr_ctrl && !i_hwdata[`ACS_CTRL_GO];

    // trigger and software sets win over any clear in the same cycle
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            go_q <= 1'b0; // R7
        end else if (i_trig_special || sw_go_set) begin
            go_q <= 1'b1; // R13
        end else if (sw_go_clr || conv_done || any_abort) begin
            go_q <= 1'b0; // R4
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_timer_one_clear <= 1'b0;
        end else begin
            o_timer_one_clear <= i_trig_special; // R13
        end
    end

    // ------------------------------------------------------------ timing and sar
    acs_clkdiv #(
        .INSTR_CYC(INSTR_CYC),
        .RC_CYC(RC_TAD_CYC)
    ) u_div (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_cks(cks_q),
        .o_tad(tad),
        .o_instr(instr)
    );

    acs_sar #(
        .BITS(RB)
    ) u_sar (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_start(sar_start),
        .i_step(sar_step),
        .i_cmp(i_cmp),
        .o_trial(sar_trial),
        .o_partial(sar_partial),
        .o_last(sar_last)
    );

    assign o_dac_code = sar_trial;

    // ------------------------------------------------------------ sequencer
    assign busy = (state_q != acs_st_idle);
    assign sar_start = (state_q == acs_st_acq) && tad;
    assign sar_step = (state_q == acs_st_conv) && tad;
    assign conv_done = sar_step && sar_last && !sw_go_clr && !sleep_abort && !off_abort;
    assign sleep_abort = busy && i_sleep && !rc_sel; // R8 R12
    assign off_abort = busy && !on_q;
    assign any_abort = busy && (sw_go_clr || sleep_abort || off_abort);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= acs_st_idle; // R7
        end else if (any_abort || conv_done) begin
            state_q <= acs_st_idle; // R5
        end else begin
            unique case (state_q)
                acs_st_idle: begin
                    if (go_q && o_analog_en) begin
                        state_q <= rc_sel ? acs_st_wait : acs_st_acq; // R9
                    end
                end
                acs_st_wait: begin
                    if (instr) begin
                        state_q <= acs_st_acq; // R9
                    end
                end
                acs_st_acq: begin
                    if (tad) begin
                        state_q <= acs_st_conv;
                    end
                end
                acs_st_conv: state_q <= acs_st_conv;
            endcase
        end
    end

    // sleep power-down holds until the core leaves sleep; converter_on is untouched
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            suspend_q <= 1'b0;
        end else if (sleep_abort) begin
            suspend_q <= 1'b1; // R12
        end else if (conv_done && i_sleep && !mask_q[`ACS_IRQ_DONE]) begin
            suspend_q <= 1'b1; // R11
        end else if (!i_sleep) begin
            suspend_q <= 1'b0;
        end
    end

    assign o_analog_en = on_q && !suspend_q; // R1
    assign o_sample = o_analog_en && (state_q != acs_st_conv);

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_wake <= 1'b0;
        end else begin
            o_wake <= conv_done && i_sleep && mask_q[`ACS_IRQ_DONE]; // R10
        end
    end

    // ------------------------------------------------------------ result bytes
    // partial loads happen only once bit trials have begun
    assign load_full = sar_step && sar_last && !any_abort;
    assign load_part = (state_q == acs_st_conv) && sw_go_clr; // R5
    assign load_val = load_full ? {sar_trial[RB-1:1], i_cmp} : sar_partial; // R6

    // no reset: contents survive any reset and are unknown at power-on
    always_ff @(posedge i_mclk) begin
        if (load_full || load_part) begin
            if (!just_q) begin
                res_hi_q <= load_val[9:2]; // R16 R4
                res_lo_q <= {load_val[1:0], 6'h00}; // R17
            end else begin
                res_hi_q <= {6'h00, load_val[9:8]};
                res_lo_q <= load_val[7:0];
            end
        end else if (wr_pend_q && addr_q == `ACS_OFF_RES_HI) begin
            res_hi_q <= i_hwdata[7:0]; // R15
        end else if (wr_pend_q && addr_q == `ACS_OFF_RES_LO) begin
            res_lo_q <= i_hwdata[7:0];
        end
    end

    // ------------------------------------------------------------ interrupts
    always_comb begin
        ev = '0;
        ev[`ACS_IRQ_DONE] = conv_done; // R4
        ev[`ACS_IRQ_ABORT] = any_abort;
        ev[`ACS_IRQ_TRIG] = i_trig_special;
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= ev | (st_q & ~(wr_st ? i_hwdata[`ACS_IRQ_W-1:0] : '0));
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mask_q <= '0;
        end else if (wr_pend_q && addr_q == `ACS_OFF_IRQ_MASK) begin
            mask_q <= i_hwdata[`ACS_IRQ_W-1:0];
        end
    end

    assign o_irq = |(st_q & mask_q);

endmodule

// ==== testbench/acs_top_props.sv ====
// port assertions for the conversion sequencer
module acs_top_props
    import acs_pkg::*;
#(
    parameter int RC_TAD_CYC = 200,
    parameter int INSTR_CYC = 4
) (
    // clock, reset and bus
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [7:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    input wire logic [31:0] o_hrdata,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    // front end and core
    input wire logic i_cmp,
    input wire logic o_analog_en,
    input wire logic o_sample,
    input wire logic [9:0] o_dac_code,
    input wire logic i_sleep,
    input wire logic i_trig_special,
    input wire logic o_timer_one_clear,
    input wire logic o_wake,
    input wire logic o_irq
);
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    logic acc;
    logic wr_acc;
    assign acc = i_hsel && i_htrans[1] && i_hready;
    assign wr_acc = acc && i_hwrite;
    sequence rd_wait_s;
        !o_hreadyout ##1 o_hreadyout;
    endsequence
    sequence trial_start_s;
        $fell(o_sample) && o_analog_en;
    endsequence
    wr_nowait_a: assert property (wr_acc |=> o_hreadyout)
        else $error("write data phase stalled");
    rd_wait_a: assert property (acc && !i_hwrite |=> rd_wait_s)
        else $error("read data phase not one wait");
    first_trial_a: assert property (trial_start_s |-> o_dac_code == 10'h200)
        else $error("first trial code wrong");
    sample_power_a: assert property (o_sample |-> o_analog_en)
        else $error("sampling while unpowered");
    trig_clear_a: assert property (i_trig_special |=> o_timer_one_clear)
        else $error("timer clear missing after trigger");
    clear_cause_a: assert property (o_timer_one_clear |-> $past(i_trig_special))
        else $error("timer clear without trigger");
    wake_cause_a: assert property (o_wake |-> $past(i_sleep) ##1 !o_wake)
        else $error("wake pulse wrong");
    sleep_dark_a: assert property (i_sleep && !o_analog_en ##1 i_sleep |-> !o_analog_en)
        else $error("converter powered up in sleep");
    irq_drop_a: assert property ($fell(o_irq) |-> $past(wr_acc, 2))
        else $error("interrupt dropped without a write");
endmodule

bind acs_top acs_top_props #(.RC_TAD_CYC(RC_TAD_CYC), .INSTR_CYC(INSTR_CYC)) i_acs_top_props (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans),
    .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp), .i_cmp(i_cmp),
    .o_analog_en(o_analog_en), .o_sample(o_sample), .o_dac_code(o_dac_code), .i_sleep(i_sleep),
    .i_trig_special(i_trig_special), .o_timer_one_clear(o_timer_one_clear), .o_wake(o_wake),
    .o_irq(o_irq));

// ==== testbench/acs_front_model.sv ====
// comparator front end model seen by the sequencer
module acs_front_model (
    // clock and converter state
    input wire logic i_mclk,
    input wire logic i_analog_en,
    input wire logic i_sample,
    input wire logic [9:0] i_dac_code,
    // analog level under test
    input wire logic [9:0] i_vin,
    // decision
    output logic o_cmp
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip_q = 1'h0;
    // no valid decision when unpowered or tracking, so it churns
    always @(posedge i_mclk) begin
        flip_q <= !flip_q;
    end
    assign o_cmp = (i_analog_en && !i_sample) ? (i_vin >= i_dac_code) : flip_q;
endmodule

// ==== testbench/test_acs_top.sv ====
// self-checking bench for the conversion sequencer
`include "acs_params.svh"
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin fail_count++; \
    $display("unexpected %s expected %0h seen %0h", n, e, s); end end
module test_acs_top
    import acs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'h0, i_rst_n = 1'h0, i_hsel = 1'h0, i_hwrite = 1'h0, i_sleep = 1'h0, i_trig_special = 1'h0;
    logic [7:0] i_haddr = 8'h0, c;
    logic [1:0] i_htrans = 2'h0;
    logic [31:0] i_hwdata = 32'h0, o_hrdata, ev;
    logic [9:0] vin = 10'h0, o_dac_code;
    logic o_hreadyout, o_hresp, i_cmp, o_analog_en, o_sample, o_timer_one_clear, o_wake, o_irq;
    logic rd_ph = 1'h0;
    int fail_count = 0, total_checks = 0, wakes = 0;
    logic [31:0] expq[$];

    acs_top #(.RC_TAD_CYC(4), .INSTR_CYC(`ACS_INSTR_CYC)) i_acs_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_hsel(i_hsel), .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(3'h2),
        .i_hwdata(i_hwdata), .i_hready(o_hreadyout), .o_hrdata(o_hrdata), .o_hreadyout(o_hreadyout),
        .o_hresp(o_hresp), .i_cmp(i_cmp), .o_analog_en(o_analog_en), .o_sample(o_sample),
        .o_dac_code(o_dac_code), .i_sleep(i_sleep), .i_trig_special(i_trig_special),
        .o_timer_one_clear(o_timer_one_clear), .o_wake(o_wake), .o_irq(o_irq));
    acs_front_model i_acs_front_model (.i_mclk(i_mclk), .i_analog_en(o_analog_en), .i_sample(o_sample),
        .i_dac_code(o_dac_code), .i_vin(vin), .o_cmp(i_cmp));

    initial begin
        forever #4 i_mclk = !i_mclk;
    end

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        i_hsel <= 1'h1;
        i_haddr <= a;
        i_hwrite <= w;
        i_htrans <= 2'h2;
        @(posedge i_mclk);
        while (o_hreadyout !== 1'h1) @(posedge i_mclk);
        i_htrans <= 2'h0;
        i_hwdata <= d;
        @(posedge i_mclk);
        while (o_hreadyout !== 1'h1) @(posedge i_mclk);
        // select stays up with an idle transfer so a following call never toggles it in one step
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'h1, a, d);
    endtask

    // expectation queued before the address phase so the monitor never runs dry
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'h0, a, 32'h0);
    endtask

    task automatic conv(input logic [7:0] cv, input logic [9:0] v, input logic t);
        logic [15:0] p;
        p = cv[7] ? {6'h0, v} : {v, 6'h0};
        vin <= v;
        wr(`ACS_OFF_CTRL, cv);
        @(posedge i_mclk);
        `CHK("analog_en", 1'h1, o_analog_en)
        `CHK("sample", 1'h1, o_sample)
        if (t) begin
            // converter already powered and tracking before the trigger
            i_trig_special <= 1'h1;
            @(posedge i_mclk);
            i_trig_special <= 1'h0;
            @(posedge i_mclk);
            `CHK("timer_clear", 1'h1, o_timer_one_clear)
            // trigger flag would hold the interrupt up before completion
            rd(`ACS_OFF_IRQ_ST, 32'h4);
            wr(`ACS_OFF_IRQ_ST, 32'h4);
        end else begin
            wr(`ACS_OFF_CTRL, cv | 8'h02);
        end
        rd(`ACS_OFF_CTRL, cv | 8'h02);
        repeat (3000) if (o_irq !== 1'h1) @(posedge i_mclk);
        rd(`ACS_OFF_CTRL, cv);
        rd(`ACS_OFF_RES_HI, p[15:8]);
        rd(`ACS_OFF_RES_LO, p[7:0]);
        rd(`ACS_OFF_IRQ_ST, 32'h1);
        wr(`ACS_OFF_IRQ_ST, 32'h7);
    endtask

    always @(posedge i_mclk) begin
        if (rd_ph && o_hreadyout) begin
            ev = expq.pop_front();
            `CHK("hrdata", ev, o_hrdata)
            rd_ph = 1'h0;
        end
        if (i_hsel && i_htrans[1] && o_hreadyout)
            rd_ph = !i_hwrite;
        if (o_wake === 1'h1)
            wakes++;
    end

    initial begin
        repeat (20000) @(posedge i_mclk);
        fail_count++;
        print_verdict();
    end

    initial begin
        void'($urandom(26830));
        repeat (16) @(posedge i_mclk);
        i_rst_n <= 1'h1;
        @(posedge i_mclk);
        rd(`ACS_OFF_CTRL, 32'h0);
        rd(`ACS_OFF_IRQ_ST, 32'h0);
        rd(8'h20, 32'h0);
        wr(`ACS_OFF_IRQ_MASK, 32'h7);
        // both clocks, both justifications, a sleep-through run, a trigger run
        for (int m = 0; m < 5; m++) begin
            c = {m[0], 2'h0, m[1] ? 3'h7 : 3'h0, 2'h1};
            i_sleep <= (m == 3);
            conv(c, 10'($urandom), m == 4);
        end
        `CHK("wakes", 1, wakes)
        vin <= 10'h3ff;
        wr(`ACS_OFF_CTRL, 32'h3);
        repeat (12) @(posedge i_mclk);
        wr(`ACS_OFF_CTRL, 32'h1);
        rd(`ACS_OFF_RES_HI, 32'hff);
        rd(`ACS_OFF_RES_LO, 32'hc0);
        rd(`ACS_OFF_IRQ_ST, 32'h2);
        wr(`ACS_OFF_IRQ_ST, 32'h7);
        wr(`ACS_OFF_CTRL, 32'h3);
        repeat (6) @(posedge i_mclk);
        i_sleep <= 1'h1;
        repeat (3) @(posedge i_mclk);
        `CHK("analog_en", 1'h0, o_analog_en)
        rd(`ACS_OFF_CTRL, 32'h1);
        i_sleep <= 1'h0;
        rd(`ACS_OFF_IRQ_ST, 32'h2);
        wr(`ACS_OFF_IRQ_ST, 32'h7);
        // rc run through sleep with the done interrupt masked off
        wr(`ACS_OFF_IRQ_MASK, 32'h6);
        i_sleep <= 1'h1;
        wr(`ACS_OFF_CTRL, 32'h1f);
        repeat (100) @(posedge i_mclk);
        `CHK("analog_en", 1'h0, o_analog_en)
        rd(`ACS_OFF_CTRL, 32'h1d);
        rd(`ACS_OFF_IRQ_ST, 32'h1);
        i_sleep <= 1'h0;
        wr(`ACS_OFF_IRQ_ST, 32'h7);
        wr(`ACS_OFF_IRQ_MASK, 32'h7);
        wr(`ACS_OFF_RES_HI, 32'ha5);
        rd(`ACS_OFF_RES_HI, 32'ha5);
        i_rst_n <= 1'h0;
        repeat (3) @(posedge i_mclk);
        `CHK("analog_en", 1'h0, o_analog_en)
        i_rst_n <= 1'h1;
        @(posedge i_mclk);
        rd(`ACS_OFF_CTRL, 32'h0);
        rd(`ACS_OFF_RES_HI, 32'ha5);
        @(posedge i_mclk);
        print_verdict();
    end
endmodule
